//--- sas_defines.svh
// Offsets, field positions, reset values and timing counts for the converter sequencer
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH
`define SAS_ADDR_MODE 16'hff80
`define SAS_ADDR_PINSEL 16'hff84
`define SAS_ADDR_RESULT 16'hff81
`define SAS_ADDR_EDGE 16'hff82
`define SAS_ADDR_FLAG 16'hff83
`define SAS_MODE_RESET 8'h01
`define SAS_PINSEL_RESET 4'h0
`define SAS_EDGE_RESET 2'h0
`define SAS_BIT_RUN 7
`define SAS_BIT_TRG 6
`define SAS_BIT_SPD_HI 5
`define SAS_BIT_SPD_LO 4
`define SAS_CH_MSB 3
`define SAS_CH_LSB 1
`define SAS_BIT_HS 0
`define SAS_PINSEL_MAX 4'h8
// Clock cycles per quarter of an fx period; times below are in quarter-fx units
`define SAS_CLK_PER_QFX 8'h01
`define SAS_SMP_80 8'h24
`define SAS_DLY_80 8'h18
`define SAS_BIT_80 8'h20
`define SAS_SMP_40 8'h12
`define SAS_DLY_40 8'h0c
`define SAS_BIT_40 8'h10
`define SAS_SMP_50 8'h15
`define SAS_DLY_50 8'h12
`define SAS_BIT_50 8'h14
`define SAS_SMP_100 8'h2a
`define SAS_DLY_100 8'h24
`define SAS_BIT_100 8'h28
`endif

//--- sas_pkg.sv
// Types shared by the converter sequencer
package sas_pkg;
  typedef enum logic [2:0] {
    SAS_IDLE = 3'b000,
    SAS_WAIT = 3'b001,
    SAS_DELAY = 3'b010,
    SAS_SAMPLE = 3'b011,
    SAS_BITS = 3'b100
  } sas_state_e;

  typedef struct packed {
    sas_state_e st;
    logic [7:0] mode;
    logic [3:0] pinsel;
    logic [1:0] edge_mode;
    logic [7:0] approximation_reg;
    logic [2:0] bit_idx;
    logic [7:0] cnt;
    logic [7:0] div;
    logic [7:0] result;
    logic flag;
    logic irq;
    logic [7:0] rdata;
    logic trg_s1;
    logic trg_s2;
    logic trg_s3;
    logic [7:0] analog_en;
    logic [7:0] pullup_en;
    logic smp_on;
    logic conv_on;
  } sas_regs_s;
endpackage : sas_pkg

//--- sas_sequencer.sv
// Successive-approximation converter sequencer with its CPU register port
`timescale 1ns/100ps
`default_nettype none
`include "sas_defines.svh"

// Notes on behaviour
// - Pin-select code n (0..8) makes pins 0..n-1 analog, rest stay ports.
// - Pin-select resets to zero and its upper four bits read zero.
// - Analog pins never get the internal pull-up, whatever the option bit says.
// - After sampling, set MSB, compare against half reference, keep if at or above.
// - Each lower bit is set, tap follows decided bits, kept when input >= tap.
// - After bit 0 the approximation is copied to the result and interrupt raised.
// - Conversions repeat while the run bit is one; clearing it stops them.
// - Result register content after reset is undefined.
// - Sampling and start delay follow speed setting, doubled for halved clock.
// - Result is INT(Vin/Vref*256+0.5), half-step rounding by the taps.
// - Trigger select and run set: wait, each valid edge seen while waiting starts one conversion.
// - Hardware start: after completion stay idle until the next edge.
// - Hardware start: rewrite with run set aborts and waits for a fresh edge.
// - Either mode: rewrite clearing run stops the conversion at once.
// - Software start: convert at once and restart back to back on completion.
// - Software start: rewrite with run set restarts with the new settings.
// - Every completion without a pin-select write in its cycle sets the end flag so software can poll it.
// - Trigger edge chosen by a separate edge-mode register resetting to zero.
// - Mode register holds run, trigger, speed, channel, high-speed; resets 01H.
// - Mode or pin-select write in the completion cycle suppresses store and irq.
// - A result read in the completion cycle returns the old value first.
module sas_sequencer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic clock_divide_select,
  input wire logic port_pullup_option_bit,
  input wire logic external_trigger_input,
  input wire logic comp_ge,
  output logic [7:0] tap_code,
  output logic [2:0] channel_sel,
  output logic sample_on,
  output logic converting,
  output logic [7:0] analog_pin_en,
  output logic [7:0] pullup_en,
  output logic conversion_end_irq,
  output logic conversion_end_flag
);
  logic rst_m_b;
  logic rst_s_b;
  sas_pkg::sas_regs_s q;
  sas_pkg::sas_regs_s d;

  // Reset release through two stages; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_b <= 1'b0;
      rst_s_b <= 1'b0;
    end else begin
      rst_m_b <= 1'b1;
      rst_s_b <= rst_m_b;
    end
  end

  logic [7:0] smp_t;
  logic [7:0] dly_t;
  logic [7:0] bit_t;
  logic tick;
  logic mode_wr;
  logic pin_wr;
  logic trg_edge;
  logic run_new;
  logic trg_new;
  logic edge_wr;
  logic flag_clr;
  logic [7:0] tm_mode;

  // A mode write times its first delay from the speed it writes, not the one it replaces
  assign tm_mode = mode_wr ? reg_wdata : q.mode;

  // Per-speed timing; unlisted codes fall back to the 80 row (code 001)
  always_comb begin
    case ({tm_mode[`SAS_BIT_SPD_HI], tm_mode[`SAS_BIT_SPD_LO], tm_mode[`SAS_BIT_HS]})
      3'b001: begin
        smp_t = `SAS_SMP_80;
        dly_t = `SAS_DLY_80;
        bit_t = `SAS_BIT_80;
      end
      3'b011: begin
        smp_t = `SAS_SMP_40;
        dly_t = `SAS_DLY_40;
        bit_t = `SAS_BIT_40;
      end
      3'b100: begin
        smp_t = `SAS_SMP_50;
        dly_t = `SAS_DLY_50;
        bit_t = `SAS_BIT_50;
      end
      3'b101: begin
        smp_t = `SAS_SMP_100;
        dly_t = `SAS_DLY_100;
        bit_t = `SAS_BIT_100;
      end
      default: begin
        smp_t = `SAS_SMP_80;
        dly_t = `SAS_DLY_80;
        bit_t = `SAS_BIT_80;
      end
    endcase
    // Halved clock doubles every span, bit time included
    if (!clock_divide_select) begin
      smp_t = {smp_t[6:0], 1'b0};
      dly_t = {dly_t[6:0], 1'b0};
      bit_t = {bit_t[6:0], 1'b0};
    end
  end

  assign tick = (q.div == 8'h00);
  assign mode_wr = reg_wr && (reg_addr == `SAS_ADDR_MODE);
  assign pin_wr = reg_wr && (reg_addr == `SAS_ADDR_PINSEL);
  assign run_new = reg_wdata[`SAS_BIT_RUN];
  assign trg_new = reg_wdata[`SAS_BIT_TRG];
  assign edge_wr = reg_wr && (reg_addr == `SAS_ADDR_EDGE);
  assign flag_clr = reg_wr && (reg_addr == `SAS_ADDR_FLAG) && !reg_wdata[0];

  // Edge codes: 00 falling, 01 rising, others both edges
  always_comb begin
    case (q.edge_mode)
      2'b00: trg_edge = q.trg_s3 && !q.trg_s2;
      2'b01: trg_edge = !q.trg_s3 && q.trg_s2;
      2'b10: trg_edge = q.trg_s3 ^ q.trg_s2;
      2'b11: trg_edge = q.trg_s3 ^ q.trg_s2;
      default: trg_edge = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    d.irq = 1'b0;
    // Two flops settle the pin; the third keeps the previous level for the edge test
    d.trg_s1 = external_trigger_input;
    d.trg_s2 = q.trg_s1;
    d.trg_s3 = q.trg_s2;
    // At one clock per quarter-fx the divider rests at zero and every cycle ticks
    d.div = tick ? (`SAS_CLK_PER_QFX - 8'h01) : (q.div - 8'h01);
    // Registered read: a read in the completion cycle sees the old result
    if (reg_rd) begin
      case (reg_addr)
        `SAS_ADDR_MODE: d.rdata = q.mode;
        `SAS_ADDR_PINSEL: d.rdata = {4'h0, q.pinsel};
        `SAS_ADDR_RESULT: d.rdata = q.result;
        `SAS_ADDR_EDGE: d.rdata = {6'h00, q.edge_mode};
        `SAS_ADDR_FLAG: d.rdata = {7'h00, q.flag};
        default: d.rdata = 8'h00;
      endcase
    end

    if (pin_wr) begin
      d.pinsel = reg_wdata[3:0];
    end
    if (edge_wr) begin
      d.edge_mode = reg_wdata[1:0];
    end
    // Mode writes leave the flag alone; only its own register clears it
    if (flag_clr) begin
      d.flag = 1'b0;
    end

    // A mode write overrides the sequencer in every state, so it never meets a completion
    if (mode_wr) begin
      d.mode = reg_wdata;
      d.approximation_reg = 8'h00;
      if (!run_new) begin
        d.st = sas_pkg::SAS_IDLE;
      end else if (trg_new) begin
        d.st = sas_pkg::SAS_WAIT;
      end else begin
        d.st = sas_pkg::SAS_DELAY;
        d.cnt = dly_t;
      end
    end else begin
      case (q.st)
        sas_pkg::SAS_IDLE: begin
          if (q.mode[`SAS_BIT_RUN]) begin
            d.st = q.mode[`SAS_BIT_TRG] ? sas_pkg::SAS_WAIT : sas_pkg::SAS_DELAY;
            d.cnt = dly_t;
          end
        end

        sas_pkg::SAS_WAIT: begin
          // Edges seen in other states are simply dropped
          if (trg_edge) begin
            d.st = sas_pkg::SAS_DELAY;
            d.cnt = dly_t;
          end
        end

        sas_pkg::SAS_DELAY: begin
          if (tick) begin
            if (q.cnt <= 8'h01) begin
              d.st = sas_pkg::SAS_SAMPLE;
              d.cnt = smp_t;
            end else begin
              d.cnt = q.cnt - 8'h01;
            end
          end
        end

        sas_pkg::SAS_SAMPLE: begin
          if (tick) begin
            if (q.cnt <= 8'h01) begin
              d.st = sas_pkg::SAS_BITS;
              d.approximation_reg = 8'h80;
              d.bit_idx = 3'h7;
              d.cnt = bit_t;
            end else begin
              d.cnt = q.cnt - 8'h01;
            end
          end
        end

        sas_pkg::SAS_BITS: begin
          if (tick) begin
            if (q.cnt <= 8'h01) begin
              // The tap is the trial code itself, so kept bits fix the rounding
              d.approximation_reg[q.bit_idx] = comp_ge;
              d.cnt = bit_t;
              if (q.bit_idx == 3'h0) begin
                if (!pin_wr) begin
                  d.result = {q.approximation_reg[7:1], comp_ge};
                  d.irq = 1'b1;
                  d.flag = 1'b1;
                end
                if (q.mode[`SAS_BIT_TRG]) begin
                  d.st = sas_pkg::SAS_WAIT;
                end else begin
                  d.st = sas_pkg::SAS_DELAY;
                  d.cnt = dly_t;
                end
              end else begin
                d.bit_idx = q.bit_idx - 3'h1;
                d.approximation_reg[q.bit_idx - 3'h1] = 1'b1;
              end
            end else begin
              d.cnt = q.cnt - 8'h01;
            end
          end
        end
        default: d.st = sas_pkg::SAS_IDLE;
      endcase
    end

    // Prohibited pin counts above eight are clamped to all-analog
    for (int i = 0; i < 8; i++) begin
      d.analog_en[i] = (4'(i) < d.pinsel) || (d.pinsel > `SAS_PINSEL_MAX);
      d.pullup_en[i] = port_pullup_option_bit && !d.analog_en[i];
    end

    // Status pins are registered decodes of the next state, so they switch with it
    d.smp_on = (d.st == sas_pkg::SAS_SAMPLE);
    d.conv_on = (d.st == sas_pkg::SAS_BITS);
  end

  always_ff @(posedge clk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      q.st <= sas_pkg::SAS_IDLE;
      q.mode <= `SAS_MODE_RESET;
      q.pinsel <= `SAS_PINSEL_RESET;
      q.edge_mode <= `SAS_EDGE_RESET;
      q.approximation_reg <= 8'h00;
      q.bit_idx <= 3'h0;
      q.cnt <= 8'h00;
      q.div <= 8'h00;
      q.result <= 8'h00; // Cleared for tidiness only; software must not rely on it
      q.flag <= 1'b0;
      q.irq <= 1'b0;
      q.rdata <= 8'h00;
      q.trg_s1 <= 1'b0;
      q.trg_s2 <= 1'b0;
      q.trg_s3 <= 1'b0;
      q.analog_en <= 8'h00;
      q.pullup_en <= 8'h00;
      q.smp_on <= 1'b0;
      q.conv_on <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign tap_code = q.approximation_reg;
  assign channel_sel = q.mode[`SAS_CH_MSB:`SAS_CH_LSB];
  assign sample_on = q.smp_on;
  assign converting = q.conv_on;
  assign analog_pin_en = q.analog_en;
  assign pullup_en = q.pullup_en;
  assign conversion_end_irq = q.irq;
  assign conversion_end_flag = q.flag;
endmodule : sas_sequencer
`default_nettype wire

//--- sas_monitor.sv
// Port-level assertions for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
`include "sas_defines.svh"
module sas_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] tap_code,
  input wire logic sample_on,
  input wire logic converting,
  input wire logic [7:0] analog_pin_en,
  input wire logic [7:0] pullup_en,
  input wire logic conversion_end_irq,
  input wire logic conversion_end_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  pull_off_a: assert property ((pullup_en & analog_pin_en) == 8'h00)
    else $error("pull-up on analog pin");
  irq_flag_a: assert property (conversion_end_irq |-> conversion_end_flag)
    else $error("irq without flag");
  irq_pulse_a: assert property (conversion_end_irq |=> !conversion_end_irq)
    else $error("irq too long");
  // Any mode write restarts or stops, so no bit decision may run just after it
  mode_abort_a: assert property (reg_wr && reg_addr == `SAS_ADDR_MODE |=> !converting && !sample_on)
    else $error("mode write ignored");
  pin_map_a: assert property (reg_wr && reg_addr == `SAS_ADDR_PINSEL && reg_wdata <= 8'h08 |-> ##2
    {1'b0, analog_pin_en} == (9'h001 << $past(reg_wdata, 2)) - 9'h001) else $error("analog map wrong");
  pin_top_a: assert property (reg_rd && reg_addr == `SAS_ADDR_PINSEL |=> reg_rdata[7:4] == 4'h0)
    else $error("pin select upper bits set");
  tap_msb_a: assert property ($rose(converting) |-> tap_code == 8'h80)
    else $error("first trial not msb");
  write_wins_a: assert property (reg_wr && (reg_addr == `SAS_ADDR_MODE || reg_addr == `SAS_ADDR_PINSEL)
    |=> !conversion_end_irq)
    else $error("irq despite register write");
endmodule : sas_monitor
bind sas_sequencer sas_monitor u_mon (.clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .tap_code,
  .sample_on, .converting, .analog_pin_en, .pullup_en, .conversion_end_irq, .conversion_end_flag);
`default_nettype wire

//--- sas_analog_model.sv
// Analog inputs, comparator and external trigger source
`timescale 1ns/100ps
`default_nettype none
module sas_analog_model (
  input wire logic clk,
  input wire logic [2:0] channel_sel,
  input wire logic [7:0] tap_code,
  output logic comp_ge,
  output logic external_trigger_input
);
  logic [7:0] vin [8];
  initial external_trigger_input = 1'b0;
  // Inputs are held as codes, so an exact tap match counts as at or above
  assign comp_ge = vin[channel_sel] >= tap_code;
  task pulse;
    @(posedge clk);
    #1 external_trigger_input = 1'b1;
    repeat (4) @(posedge clk);
    #1 external_trigger_input = 1'b0;
  endtask : pulse
endmodule : sas_analog_model
`default_nettype wire

//--- sas_sequencer_bench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module sas_sequencer_bench;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, got;
  logic clock_divide_select = 1'b1, port_pullup_option_bit = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, tap_code, analog_pin_en, pullup_en, m, r, e;
  logic [2:0] channel_sel, c;
  logic comp_ge, external_trigger_input, sample_on, converting, conversion_end_irq, conversion_end_flag;
  int n_errors = 0, n_compared = 0, seed = 96051, cnt, dl;
  logic [7:0] tbl [5] = '{8'h81, 8'h91, 8'ha0, 8'ha1, 8'h81};
  logic [7:0] smp_n [5] = '{8'h24, 8'h24, 8'h2a, 8'h2a, 8'h48};
  logic [7:0] dly_n [5] = '{8'h18, 8'h18, 8'h24, 8'h24, 8'h30};
  always #2 clk = ~clk;
  sas_sequencer u_dut (.clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .clock_divide_select,
    .port_pullup_option_bit, .external_trigger_input, .comp_ge, .tap_code, .channel_sel, .sample_on, .converting,
    .analog_pin_en, .pullup_en, .conversion_end_irq, .conversion_end_flag);
  sas_analog_model u_ana (.clk, .channel_sel, .tap_code, .comp_ge, .external_trigger_input);
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask : wr
  task rd(input logic [15:0] a);
    @(posedge clk);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    r = reg_rdata;
  endtask : rd
  // Waits for a completion pulse, counting sampling cycles on the way
  task wt(input int lim);
    got = 1'b0;
    cnt = 0;
    dl = 0;
    for (int k = 0; k < lim && !got; k++) begin
      @(posedge clk);
      #1 got = conversion_end_irq;
      cnt += sample_on;
      dl += !sample_on && !converting && !got;
    end
  endtask : wt
  task stop_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    n_errors++;
    stop_test;
  end
  initial begin
    for (int i = 0; i < 8; i++) u_ana.vin[i] = $random(seed);
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    rd(16'hff84);
    chk("pinsel", r, 8'h00);
    rd(16'hff80);
    chk("mode", r, 8'h01);
    rd(16'hff82);
    chk("edge", r, 8'h00);
    $display("reset values done");
    for (int n = 0; n <= 8; n++) begin
      port_pullup_option_bit = $random(seed);
      e = 8'((9'h001 << n) - 9'h001);
      wr(16'hff84, 8'(n));
      rd(16'hff84);
      chk("pinsel", r, 8'(n));
      chk("analog", analog_pin_en, e);
      chk("pullup", pullup_en, {8{port_pullup_option_bit}} & ~e);
    end
    // All pins analog before any channel is chosen
    wr(16'hff84, 8'hf8);
    rd(16'hff84);
    chk("pinsel", r, 8'h08);
    $display("pin select done");
    for (int i = 0; i < 5; i++) begin
      c = $random(seed);
      clock_divide_select = (i == 0) || (i == 3); // rows 0 and 3 run with the undivided clock, the others halved
      m = tbl[i] | {4'h0, c, 1'b0};
      wr(16'hff80, m);
      wt(1000);
      chk("sample", cnt[7:0], smp_n[i]);
      // The first delay cycle passes while the write task finishes
      chk("delay", dl[7:0] + 8'h01, dly_n[i]);
      chk("channel", {5'h00, channel_sel}, {5'h00, c});
      rd(16'hff81);
      chk("result", r, u_ana.vin[c]);
      chk("flag", conversion_end_flag, 8'h01);
    end
    wt(1000);
    chk("again", cnt[7:0], 8'h48);
    $display("software start done");
    clock_divide_select = 1'b1;
    wr(16'hff80, 8'h81);
    repeat (100) @(posedge clk);
    wr(16'hff80, 8'h01);
    chk("stop", converting, 8'h00);
    wt(600);
    chk("stopped", got, 8'h00);
    chk("flag kept", conversion_end_flag, 8'h01);
    wr(16'hff83, 8'h00);
    chk("flag clr", conversion_end_flag, 8'h00);
    $display("stop done");
    wr(16'hff82, 8'h01);
    wr(16'hff80, 8'hcf);
    wt(400);
    chk("standby", got, 8'h00);
    u_ana.pulse();
    wt(1000);
    chk("hw done", got, 8'h01);
    rd(16'hff81);
    chk("hw result", r, u_ana.vin[7]);
    wt(600);
    chk("hw idle", got, 8'h00);
    u_ana.pulse();
    repeat (100) @(posedge clk);
    wr(16'hff80, 8'hcf);
    wt(600);
    chk("abort", got, 8'h00);
    u_ana.pulse();
    wt(1000);
    chk("restart", got, 8'h01);
    wr(16'hff82, 8'h00);
    wr(16'hff80, 8'hcf);
    u_ana.pulse();
    wt(1000);
    chk("falling", got, 8'h01);
    rd(16'hff8f);
    chk("unmapped", r, 8'h00);
    $display("hardware start done");
    stop_test;
  end
endmodule : sas_sequencer_bench
`default_nettype wire
